// ---- design/fdcs_drive_decode.sv ----
// Internal two drive select and motor decode, normal or swapped
`timescale 1ns/10ps
`default_nettype none
module fdcs_drive_decode
	import fdcs_pkg::*;
(
	input  wire logic [1:0] drive_num_i,
	input  wire logic       motor0_en_i,
	input  wire logic       motor1_en_i,
	input  wire logic       swap_i,
	output logic            drive_zero_select_n_o,
	output logic            drive_one_select_n_o,
	output logic            motor_zero_on_n_o,
	output logic            motor_one_on_n_o
);

	// ==========================================================
	// Normal decode terms, one binary drive number
	wire sel0_n = ~((drive_num_i == 2'h0) & motor0_en_i);
	wire sel1_n = ~((drive_num_i == 2'h1) & motor1_en_i);

	// Swap exchanges both selects and motors
	assign drive_zero_select_n_o = swap_i ? sel1_n : sel0_n;
	assign drive_one_select_n_o  = swap_i ? sel0_n : sel1_n;
	assign motor_zero_on_n_o     = swap_i ? ~motor1_en_i : ~motor0_en_i;
	assign motor_one_on_n_o      = swap_i ? ~motor0_en_i : ~motor1_en_i;

endmodule
`default_nettype wire

// ---- design/fdcs_edge_flag.sv ----
// Edge detector that either latches a sticky flag or toggles a bit
`timescale 1ns/10ps
`default_nettype none
module fdcs_edge_flag
	import fdcs_pkg::*;
#(
	parameter bit RISING = 1'b1,
	parameter bit TOGGLE = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic sig_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	// ==========================================================
	// Edge detection
	logic prev_reg;
	logic flag_reg;
	logic flag_next;
	wire  edge_seen = RISING ? (sig_i & ~prev_reg) : (~sig_i & prev_reg);

	// Toggle mode flips, latch mode sets and set wins over clear
	assign flag_next = TOGGLE ? (flag_reg ^ edge_seen) :
		(edge_seen ? 1'b1 : (clr_i ? 1'b0 : flag_reg));

	// History follows the input through reset, so no false edge after it
	always_ff @(posedge clk_i) begin
		prev_reg <= sig_i;
		if (reset_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;

endmodule
`default_nettype wire

// ---- design/fdcs_pkg.sv ----
// Constants and types shared by the drive control and status register bank
package fdcs_pkg;

	// ==========================================================
	// Host I/O addresses
	localparam logic [15:0] FDCS_ADDR_STATUS_SECOND = 16'h03f1;
	localparam logic [15:0] FDCS_ADDR_OUTPUT_CTRL   = 16'h03f2;
	localparam logic [15:0] FDCS_ADDR_TAPE_ASSIGN   = 16'h03f3;
	localparam logic [15:0] FDCS_ADDR_DIGITAL_IN    = 16'h03f7;

	// ==========================================================
	// Output control field positions
	localparam int FDCS_DOC_SEL_LO   = 0;
	localparam int FDCS_DOC_SEL_HI   = 1;
	localparam int FDCS_DOC_RUN      = 2;
	localparam int FDCS_DOC_DMA_EN   = 3;
	localparam int FDCS_DOC_MOTOR0   = 4;
	localparam int FDCS_DOC_MOTOR1   = 5;

	// ==========================================================
	// Second status field positions
	localparam int FDCS_SS_WRITE_ENABLE_LINE     = 2;
	localparam int FDCS_SS_RDATA     = 3;
	localparam int FDCS_SS_WDATA     = 4;
	localparam int FDCS_SS_SEL0      = 5;
	localparam int FDCS_SS_SEL1      = 6;

	// ==========================================================
	// Reset values
	localparam logic [7:0] FDCS_DOC_RESET  = 8'h00;
	localparam logic [1:0] FDCS_TAPE_RESET = 2'h0;
	localparam logic [1:0] FDCS_RSV_ONES   = 2'h3;

	// ==========================================================
	// Timing
	localparam int FDCS_CLK_MHZ       = 50;
	localparam int FDCS_SRST_MIN_NS   = 100;
	localparam int FDCS_SRST_CYCLES   =
		(FDCS_SRST_MIN_NS * FDCS_CLK_MHZ + 999) / 1000;
	localparam int FDCS_SRST_CNT_W    = 3;

	// ==========================================================
	// Compatibility layouts of the second status register
	typedef enum logic [1:0] {
		FDCS_MODE_BASIC,
		FDCS_MODE_ENHANCED,
		FDCS_MODE_LATCHED
	} fdcs_status_mode_t;

endpackage

// ---- design/fdcs_regs.sv ----
// Drive control and status register bank of the floppy controller
`timescale 1ns/10ps
`default_nettype none
module fdcs_regs
	import fdcs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic [15:0]       io_addr_i,
	input  wire logic              io_rd_i,
	input  wire logic              io_wr_i,
	input  wire logic [7:0]        io_wdata_i,
	output logic      [7:0]        io_rdata_o,
	output logic                   io_rdata_oe_o,
	input  wire fdcs_status_mode_t status_mode_i,
	input  wire logic              swap_decode_i,
	input  wire logic              enhanced_floppy_i,
	input  wire logic [7:0]        drive_type_cfg_i,
	input  wire logic [1:0]        boot_drive_i,
	input  wire logic              write_enable_line_i,
	input  wire logic              write_data_i,
	input  wire logic              read_data_n_i,
	input  wire logic              fdc_irq_i,
	input  wire logic              fdc_drq_i,
	output logic                   fdc_irq_o,
	output logic                   fdc_drq_o,
	output logic                   soft_reset_o,
	output logic [1:0]             tape_drive_o,
	output logic                   drive_zero_select_n_o,
	output logic                   drive_one_select_n_o,
	output logic                   motor_zero_on_n_o,
	output logic                   motor_one_on_n_o
);

	// ==========================================================
	// Registers
	logic [7:0]                 doc_reg;
	logic [7:0]                 doc_next;
	logic [1:0]                 tape_reg;
	logic [1:0]                 tape_next;
	logic [FDCS_SRST_CNT_W-1:0] srst_cnt_reg;
	logic [FDCS_SRST_CNT_W-1:0] srst_cnt_next;
	logic [7:0]                 rdata_reg;
	logic [7:0]                 rdata_next;
	logic                       oe_reg;
	logic                       oe_next;
	logic                       rd_meta_reg;
	logic                       rd_sync_reg;

	// ==========================================================
	// Address decode
	wire sel_status = (io_addr_i == FDCS_ADDR_STATUS_SECOND);
	wire sel_doc    = (io_addr_i == FDCS_ADDR_OUTPUT_CTRL);
	wire sel_tape   = (io_addr_i == FDCS_ADDR_TAPE_ASSIGN);
	wire dir_read   = io_rd_i & (io_addr_i == FDCS_ADDR_DIGITAL_IN);
	wire wr_doc     = io_wr_i & sel_doc;
	wire wr_tape    = io_wr_i & sel_tape;

	// Mode decode from the static configuration inputs
	wire mode_basic = (status_mode_i == FDCS_MODE_BASIC);
	wire mode_enh   = (status_mode_i == FDCS_MODE_ENHANCED);
	wire mode_lat   = (status_mode_i == FDCS_MODE_LATCHED);

	// ==========================================================
	// Read data pin synchroniser
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_meta_reg <= 1'b1;
			rd_sync_reg <= 1'b1;
		end else begin
			rd_meta_reg <= read_data_n_i;
			rd_sync_reg <= rd_meta_reg;
		end
	end

	// ==========================================================
	// Edge flags and toggles
	logic wg_flag;
	logic rd_flag;
	logic wd_flag;
	logic rd_tog;
	logic wd_tog;

	// Write gate active edge, cleared by input register read
	fdcs_edge_flag #(.RISING(1'b1), .TOGGLE(1'b0)) u_wg_flag (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.sig_i   (write_enable_line_i),
		.clr_i   (dir_read),
		.flag_o  (wg_flag)
	);

	// Read data inactive edge is the rise of the low-active pin
	fdcs_edge_flag #(.RISING(1'b1), .TOGGLE(1'b0)) u_rd_flag (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.sig_i   (rd_sync_reg),
		.clr_i   (dir_read),
		.flag_o  (rd_flag)
	);

	// Write data inactive edge, not gated by write gate
	fdcs_edge_flag #(.RISING(1'b0), .TOGGLE(1'b0)) u_wd_flag (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.sig_i   (write_data_i),
		.clr_i   (dir_read),
		.flag_o  (wd_flag)
	);

	// Toggle bits for the enhanced layout
	fdcs_edge_flag #(.RISING(1'b1), .TOGGLE(1'b1)) u_rd_tog (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.sig_i   (rd_sync_reg),
		.clr_i   (1'b0),
		.flag_o  (rd_tog)
	);

	fdcs_edge_flag #(.RISING(1'b0), .TOGGLE(1'b1)) u_wd_tog (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.sig_i   (write_data_i),
		.clr_i   (1'b0),
		.flag_o  (wd_tog)
	);

	// ==========================================================
	// Drive decode
	fdcs_drive_decode u_decode (
		.drive_num_i           (doc_reg[FDCS_DOC_SEL_HI:FDCS_DOC_SEL_LO]),
		.motor0_en_i           (doc_reg[FDCS_DOC_MOTOR0]),
		.motor1_en_i           (doc_reg[FDCS_DOC_MOTOR1]),
		.swap_i                (swap_decode_i),
		.drive_zero_select_n_o (drive_zero_select_n_o),
		.drive_one_select_n_o  (drive_one_select_n_o),
		.motor_zero_on_n_o     (motor_zero_on_n_o),
		.motor_one_on_n_o      (motor_one_on_n_o)
	);

	// ==========================================================
	// Register next values
	assign doc_next  = wr_doc ? io_wdata_i : doc_reg;
	assign tape_next = wr_tape ? io_wdata_i[1:0] : tape_reg;

	// Stretch the controller reset to its least length
	assign srst_cnt_next = ~doc_reg[FDCS_DOC_RUN] ?
		FDCS_SRST_CNT_W'(FDCS_SRST_CYCLES) :
		((srst_cnt_reg != '0) ? srst_cnt_reg - 1'b1 : srst_cnt_reg);

	// Register state, hardware reset only
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			doc_reg      <= FDCS_DOC_RESET;
			tape_reg     <= FDCS_TAPE_RESET;
			srst_cnt_reg <= '0;
		end else begin
			doc_reg      <= doc_next;
			tape_reg     <= tape_next;
			srst_cnt_reg <= srst_cnt_next;
		end
	end

	// ==========================================================
	// Control outputs
	assign soft_reset_o = ~doc_reg[FDCS_DOC_RUN] | (srst_cnt_reg != '0);
	wire   dma_irq_enable = mode_enh | doc_reg[FDCS_DOC_DMA_EN];
	assign fdc_irq_o    = fdc_irq_i & dma_irq_enable;
	assign fdc_drq_o    = fdc_drq_i & dma_irq_enable;
	assign tape_drive_o = tape_reg;

	// ==========================================================
	// Read layouts
	wire [7:0] status_enh = {FDCS_RSV_ONES, doc_reg[FDCS_DOC_SEL_LO],
		wd_tog, rd_tog, write_enable_line_i,
		doc_reg[FDCS_DOC_MOTOR1], doc_reg[FDCS_DOC_MOTOR0]};
	wire [7:0] status_lat = {1'b1, drive_one_select_n_o,
		drive_zero_select_n_o, wd_flag, rd_flag, wg_flag,
		2'b11};
	wire [1:0] type_id    = drive_type_cfg_i[
		{doc_reg[FDCS_DOC_SEL_HI:FDCS_DOC_SEL_LO], 1'b0} +: 2];
	wire [7:0] tape_rd    = enhanced_floppy_i ?
		{2'b00, type_id, boot_drive_i, tape_reg} :
		{6'h00, tape_reg};
	wire       status_drv = sel_status & ~mode_basic;

	// Read mux and drive enable
	assign rdata_next = ~io_rd_i ? 8'h00 :
		(status_drv ? (mode_enh ? status_enh : status_lat) :
		(sel_doc ? doc_reg : (sel_tape ? tape_rd : 8'h00)));
	assign oe_next = io_rd_i & (status_drv | sel_doc | sel_tape);

	// Registered read answer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_reg <= 8'h00;
			oe_reg    <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			oe_reg    <= oe_next;
		end
	end

	assign io_rdata_o    = rdata_reg;
	assign io_rdata_oe_o = oe_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_status_read(logic m);
		io_rd_i && sel_status && m;
	endsequence

	AST_ENH_SEL0: assert property (
		s_status_read(mode_enh) |=> io_rdata_o[FDCS_SS_SEL0] ==
			$past(doc_reg[FDCS_DOC_SEL_LO]) && io_rdata_oe_o)
		else $error("enhanced status bit 5 not the select bit");
	AST_ENH_RSV: assert property (
		s_status_read(mode_enh) |=> io_rdata_o[7:6] == 2'b11)
		else $error("enhanced reserved bits not one");
	AST_WG_LATCH: assert property (
		$rose(write_enable_line_i) |=> wg_flag)
		else $error("write gate edge not latched");
	AST_RD_LATCH: assert property (
		$rose(rd_sync_reg) |=> rd_flag)
		else $error("read data edge not latched");
	AST_WD_LATCH: assert property (
		$fell(write_data_i) |=> wd_flag)
		else $error("write data edge not latched");
	AST_FLAG_CLR: assert property (
		dir_read && !$rose(write_enable_line_i) |=> !wg_flag)
		else $error("input read did not clear write gate flag");
	AST_LAT_SEL: assert property (
		s_status_read(mode_lat) |=> io_rdata_o[6:5] ==
			{$past(drive_one_select_n_o), $past(drive_zero_select_n_o)})
		else $error("latched status selects wrong");
	AST_DOC_WRITE: assert property (
		wr_doc |=> doc_reg == $past(io_wdata_i) &&
			($past(io_wdata_i[FDCS_DOC_RUN]) || soft_reset_o))
		else $error("output control write lost");
	AST_ONE_SEL: assert property (
		!(!drive_zero_select_n_o && !drive_one_select_n_o))
		else $error("two drives selected");
	AST_SRST_MIN: assert property (
		$rose(soft_reset_o) |-> soft_reset_o [*5])
		else $error("software reset too short");
	AST_SRST_HOLD: assert property (
		!doc_reg[FDCS_DOC_RUN] |-> soft_reset_o)
		else $error("controller left reset while bit low");
	AST_DMA_GATE: assert property (
		!mode_enh && !doc_reg[FDCS_DOC_DMA_EN] |-> !fdc_irq_o && !fdc_drq_o)
		else $error("request passed while disabled");
	AST_DMA_ENH: assert property (
		mode_enh |-> fdc_irq_o == fdc_irq_i && fdc_drq_o == fdc_drq_i)
		else $error("enhanced mode request gated");
	AST_DEC_NORM: assert property (
		!swap_decode_i && doc_reg[1:0] == 2'h0 && doc_reg[FDCS_DOC_MOTOR0]
			|-> !drive_zero_select_n_o && !motor_zero_on_n_o)
		else $error("normal decode drive 0 wrong");
	AST_DEC_SWAP: assert property (
		swap_decode_i |-> motor_zero_on_n_o == !doc_reg[FDCS_DOC_MOTOR1]
			&& motor_one_on_n_o == !doc_reg[FDCS_DOC_MOTOR0])
		else $error("swapped motor decode wrong");
	AST_TAPE_KEEP: assert property (
		soft_reset_o && !wr_tape |=> $stable(tape_reg))
		else $error("tape register changed in reset");
	AST_TAPE_NORM: assert property (
		io_rd_i && sel_tape && !enhanced_floppy_i |=> io_rdata_o[7:2] == 6'h00)
		else $error("normal tape read upper bits set");
	AST_TAPE_ENH: assert property (
		io_rd_i && sel_tape && enhanced_floppy_i |=>
			io_rdata_o[5:2] == {$past(type_id), $past(boot_drive_i)})
		else $error("enhanced tape read wrong");
	AST_BASIC_Z: assert property (
		s_status_read(mode_basic) |=> !io_rdata_oe_o)
		else $error("basic mode status read drove bus");

endmodule
`default_nettype wire

// ---- testbench/fdcs_drive_model.sv ----
// Behavioural pair of floppy drives answering select and motor lines
`timescale 1ns/10ps
`default_nettype none
module fdcs_drive_model #(
	parameter int PERIOD = 16
) (
	input  wire logic clk_i,
	input  wire logic sel0_n_i,
	input  wire logic sel1_n_i,
	input  wire logic mot0_n_i,
	input  wire logic mot1_n_i,
	output logic      read_data_n_o
);
	// ========
	// Flux pulse timing of a spinning, selected drive
	logic spin;
	int   cnt_reg;

	assign spin = (!sel0_n_i && !mot0_n_i) || (!sel1_n_i && !mot1_n_i);

	// Pulse counter restarts whenever no drive is spinning
	always_ff @(posedge clk_i) begin
		cnt_reg <= (spin && cnt_reg < PERIOD - 1) ? cnt_reg + 1 : 0;
	end

	// Idle line rests at its pull-up level
	assign read_data_n_o = !(spin && cnt_reg < 2);
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the drive control and status register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import fdcs_pkg::*;
();
	// ========
	// Stimulus and observed signals
	logic              clk;
	logic              rst   = 1'b1;
	logic              rd    = 1'b0;
	logic              wr    = 1'b0;
	logic [15:0]       addr  = 16'h0000;
	logic [7:0]        wd    = 8'h00;
	fdcs_status_mode_t mode  = FDCS_MODE_BASIC;
	logic              swp   = 1'b0;
	logic              enh   = 1'b0;
	logic [7:0]        cfg   = 8'he4;
	logic [1:0]        boot  = 2'h2;
	logic              write_enable_line = 1'b0;
	logic              wdat  = 1'b0;
	logic              irq   = 1'b0;
	logic              drq   = 1'b0;
	logic [7:0]        rdat;
	logic [1:0]        tape;
	logic              oe, fi, fq, srst, s0n, s1n, m0n, m1n, rdn;
	int                err_total = 0;
	int                cmp_count = 0;

	// Free running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	fdcs_regs uut (
		.clk_i(clk), .reset_i(rst), .io_addr_i(addr),
		.io_rd_i(rd), .io_wr_i(wr), .io_wdata_i(wd),
		.io_rdata_o(rdat), .io_rdata_oe_o(oe),
		.status_mode_i(mode), .swap_decode_i(swp),
		.enhanced_floppy_i(enh), .drive_type_cfg_i(cfg),
		.boot_drive_i(boot), .write_enable_line_i(write_enable_line),
		.write_data_i(wdat), .read_data_n_i(rdn),
		.fdc_irq_i(irq), .fdc_drq_i(drq),
		.fdc_irq_o(fi), .fdc_drq_o(fq), .soft_reset_o(srst),
		.tape_drive_o(tape), .drive_zero_select_n_o(s0n),
		.drive_one_select_n_o(s1n), .motor_zero_on_n_o(m0n),
		.motor_one_on_n_o(m1n)
	);

	fdcs_drive_model drives (
		.clk_i(clk), .sel0_n_i(s0n), .sel1_n_i(s1n),
		.mot0_n_i(m0n), .mot1_n_i(m1n), .read_data_n_o(rdn)
	);

	// ========
	// Verdict, comparison and bus cycle helpers
	task automatic conclude;
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e,
			input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrr(input logic [15:0] a, input logic [7:0] d);
		cyc(1);
		addr = a;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask

	task automatic rdc(input string n, input logic [15:0] a,
			input logic [7:0] e, input logic eo);
		cyc(1);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk(n, e, rdat);
		chk("read_enable", {7'h0, eo}, {7'h0, oe});
	endtask

	task automatic hreset(input fdcs_status_mode_t m, input logic e);
		cyc(1);
		mode = m;
		enh = e;
		rst = 1'b1;
		cyc(5);
		rst = 1'b0;
	endtask

	// Expected {sel1_n, sel0_n, mot1_n, mot0_n} for a control value
	function automatic logic [3:0] dec(input logic [7:0] d,
			input logic s);
		logic a, b;
		a = !(d[1:0] == 2'h0 && d[4]);
		b = !(d[1:0] == 2'h1 && d[5]);
		return s ? {a, b, ~d[4], ~d[5]} : {b, a, ~d[5], ~d[4]};
	endfunction

	// ========
	// Scenarios
	task automatic t_reset;
		rdc("ctrl_rst", FDCS_ADDR_OUTPUT_CTRL, 8'h00, 1'b1);
		chk("srst", 8'h01, {7'h0, srst});
		chk("pins", 8'h0f, {4'h0, s1n, s0n, m1n, m0n});
		rdc("status_basic", FDCS_ADDR_STATUS_SECOND, 8'h00, 1'b0);
		rdc("unmapped", 16'h03f0, 8'h00, 1'b0);
	endtask

	task automatic t_soft;
		int n;
		wrr(FDCS_ADDR_TAPE_ASSIGN, 8'h02);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h1c);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h18);
		cyc(10);
		chk("srst_hold", 8'h01, {7'h0, srst});
		rdc("ctrl_kept", FDCS_ADDR_OUTPUT_CTRL, 8'h18, 1'b1);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h1c);
		n = 0;
		while (srst === 1'b1 && n < 20) begin
			n++;
			cyc(1);
		end
		chk("srst_len", 8'h01, {7'h0, n >= FDCS_SRST_CYCLES && n < 20});
		rdc("tape_kept", FDCS_ADDR_TAPE_ASSIGN, 8'h02, 1'b1);
	endtask

	task automatic t_decode;
		logic [7:0] v [4] = '{8'h1c, 8'h2d, 8'h0c, 8'h3e};
		for (int s = 0; s < 2; s++) begin
			swp = s[0];
			for (int i = 0; i < 4; i++) begin
				wrr(FDCS_ADDR_OUTPUT_CTRL, v[i]);
				chk("decode", {4'h0, dec(v[i], swp)}, {4'h0, s1n, s0n, m1n, m0n});
			end
		end
		swp = 1'b0;
	endtask

	task automatic t_dma;
		logic e;
		for (int m = 0; m < 3; m++) begin
			hreset(fdcs_status_mode_t'(m), 1'b0);
			irq = 1'b1;
			drq = 1'b1;
			for (int b = 0; b < 2; b++) begin
				wrr(FDCS_ADDR_OUTPUT_CTRL, {4'h0, b[0], 3'h4});
				e = (m == 1) || b[0];
				chk("irq_gate", {7'h0, e}, {7'h0, fi});
				chk("drq_gate", {7'h0, e}, {7'h0, fq});
			end
		end
	endtask

	task automatic t_enh;
		hreset(FDCS_MODE_ENHANCED, 1'b0);
		write_enable_line = 1'b1;
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h15);
		wdat = 1'b1;
		cyc(2);
		wdat = 1'b0;
		cyc(3);
		rdc("enh_status", FDCS_ADDR_STATUS_SECOND, 8'hf5, 1'b1);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h11);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h15);
		rdc("enh_soft", FDCS_ADDR_STATUS_SECOND, 8'hf5, 1'b1);
		hreset(FDCS_MODE_ENHANCED, 1'b0);
		rdc("enh_hard", FDCS_ADDR_STATUS_SECOND, 8'hc4, 1'b1);
		write_enable_line = 1'b0;
	endtask

	// Edge flags: write data fall with gate idle, gate rise, drive pulses
	task automatic t_latch;
		hreset(FDCS_MODE_LATCHED, 1'b0);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h0c);
		rdc("lat_idle", FDCS_ADDR_STATUS_SECOND, 8'he3, 1'b1);
		wdat = 1'b1;
		cyc(2);
		wdat = 1'b0;
		cyc(2);
		write_enable_line = 1'b1;
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h1c);
		cyc(40);
		rdc("lat_set", FDCS_ADDR_STATUS_SECOND, 8'hdf, 1'b1);
		wrr(FDCS_ADDR_OUTPUT_CTRL, 8'h0c);
		write_enable_line = 1'b0;
		cyc(8);
		rdc("din_read", FDCS_ADDR_DIGITAL_IN, 8'h00, 1'b0);
		rdc("lat_clr", FDCS_ADDR_STATUS_SECOND, 8'he3, 1'b1);
	endtask

	task automatic t_tape;
		logic [1:0] t;
		hreset(FDCS_MODE_BASIC, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wrr(FDCS_ADDR_TAPE_ASSIGN, {6'h3f, i[1:0]});
			rdc("tape_norm", FDCS_ADDR_TAPE_ASSIGN, {6'h00, i[1:0]}, 1'b1);
			chk("tape_pins", {6'h0, i[1:0]}, {6'h0, tape});
		end
		hreset(FDCS_MODE_BASIC, 1'b1);
		for (int d = 0; d < 4; d++) begin
			t = 2'h3 - d[1:0];
			wrr(FDCS_ADDR_OUTPUT_CTRL, {6'h01, d[1:0]});
			wrr(FDCS_ADDR_TAPE_ASSIGN, {6'h00, t});
			rdc("tape_enh", FDCS_ADDR_TAPE_ASSIGN, {2'h0, cfg[2*d +: 2], boot, t}, 1'b1);
		end
	endtask

	// ========
	// Main sequence
	initial begin
		hreset(FDCS_MODE_BASIC, 1'b0);
		t_reset;
		t_soft;
		t_decode;
		t_dma;
		t_enh;
		t_latch;
		t_tape;
		conclude;
	end

	// Watchdog, several times the expected run of under 1000 cycles
	initial begin
		#100000;
		err_total++;
		conclude;
	end
endmodule
`default_nettype wire
